// file: core/rpms_defs.vh
// Behaviour
// - main enable or aux wake edge starts supplies
// - settled and stable: host clock to HF
// - sleep keeps host supply and aux clock
// - aux rising edge from power down wakes
// - unconfirmed aux wake returns to power down
// - main enable high keeps device active
// - both enables low: everything off
// - main high: mode from status register
// - bit 7 standby, recovery within 100 us
// - bits 5,1 clear: mode 1, 25 us
// - bit 1 only: receiver on, transmitter off
// - bit 5: transmitter and receiver on
// - bit 4 half power, 0x21/0x31
// - bit 0 selects 5 V, default 5 V
`ifndef RPMS_DEFS_VH
`define RPMS_DEFS_VH

// system clock rate
`define RPMS_CLK_HZ 20000000
// auxiliary host clock rate
`define RPMS_AUX_CLK_HZ 60000
// confirmation window after the clock switch, in us
`define RPMS_CONFIRM_US 100
// longest recovery from standby, in us
`define RPMS_STBY_RECOVER_US 100
// longest recovery from mode 1, in us
`define RPMS_MODE1_RECOVER_US 25
// longest times round down to whole cycles
`define RPMS_CONFIRM_CYC (`RPMS_CONFIRM_US * (`RPMS_CLK_HZ / 1000000))
`define RPMS_STBY_RECOVER_CYC (`RPMS_STBY_RECOVER_US * (`RPMS_CLK_HZ / 1000000))
`define RPMS_MODE1_RECOVER_CYC (`RPMS_MODE1_RECOVER_US * (`RPMS_CLK_HZ / 1000000))
// system cycles per half period of the auxiliary clock
`define RPMS_AUX_HALF_CYC (`RPMS_CLK_HZ / (2 * `RPMS_AUX_CLK_HZ))

// chip status control register address and reset value
`define RPMS_CSC_ADDR 8'h00
`define RPMS_CSC_RESET 8'h01
// chip status control field positions
`define RPMS_CSC_STANDBY_BIT 7
`define RPMS_CSC_RF_ON_BIT 5
`define RPMS_CSC_HALF_PWR_BIT 4
`define RPMS_CSC_RX_ONLY_BIT 1
`define RPMS_CSC_SUPPLY_5V_BIT 0

// power mode status codes
`define RPMS_PM_DOWN 3'h0
`define RPMS_PM_SLEEP 3'h1
`define RPMS_PM_START 3'h2
`define RPMS_PM_STANDBY 3'h3
`define RPMS_PM_MODE1 3'h4
`define RPMS_PM_MODE2 3'h5
`define RPMS_PM_MODE3 3'h6
`define RPMS_PM_MODE4 3'h7

`endif

// file: core/rpms_aux_div.v
`timescale 1ns/1ns
`default_nettype none
`include "rpms_defs.vh"

// divider giving one-cycle ticks at twice the auxiliary clock rate
module rpms_aux_div #(
  parameter HALF_CYC = `RPMS_AUX_HALF_CYC
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_run,
  output reg o_tick
);

  // terminal count, cut to counter width on purpose; half periods over 512 do not fit
  localparam integer LAST_I = HALF_CYC - 1;
  localparam [8:0] LAST = LAST_I[8:0];

  // cycle counter within one half period
  reg [8:0] cnt_r;

  // count while running, tick on the last cycle of each half period
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 9'h000;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      // parked: restart the phase on the next run
      cnt_r <= 9'h000;
      o_tick <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= 9'h000;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 9'h001;
      o_tick <= 1'b0;
    end
  end

endmodule // rpms_aux_div
`default_nettype wire

// file: core/rpms_sequencer.v
`timescale 1ns/1ns
`default_nettype none
`include "rpms_defs.vh"

// power mode sequencer of the reader front end
module rpms_sequencer #(
  parameter CONFIRM_CYC = `RPMS_CONFIRM_CYC,
  parameter STBY_RECOVER_CYC = `RPMS_STBY_RECOVER_CYC,
  parameter MODE1_RECOVER_CYC = `RPMS_MODE1_RECOVER_CYC
) (
  input wire I_CLK,
  input wire I_RSTN,
  input wire I_MAIN_ENABLE,
  input wire I_AUX_WAKE_ENABLE_PIN,
  input wire I_REG_SETTLED,
  input wire I_OSC_STABLE,
  input wire I_CSC_WR,
  input wire [7:0] I_CSC_WDATA,
  output reg [7:0] O_CSC_RDATA,
  output reg O_REG_ENABLE,
  output reg O_OSC_ENABLE,
  output reg O_HOST_SUPPLY_EN,
  output reg O_HOST_CLOCK_OUTPUT,
  output reg O_HOST_CLOCK_SEL_HF,
  output reg O_TX_ENABLE,
  output reg O_RX_ENABLE,
  output reg O_HALF_POWER,
  output reg O_SUPPLY_5V,
  output reg O_RF_READY,
  output reg [2:0] O_POWER_MODE
);

  // one-hot sequencer states
  localparam [4:0] ST_DOWN = 5'h01;
  localparam [4:0] ST_SLEEP = 5'h02;
  localparam [4:0] ST_START = 5'h04;
  localparam [4:0] ST_CONFIRM = 5'h08;
  localparam [4:0] ST_ACTIVE = 5'h10;

  // full-width counts, cut to counter width on purpose below
  localparam integer CONFIRM_LAST_I = CONFIRM_CYC - 1;
  localparam integer STBY_LOAD_I = STBY_RECOVER_CYC;
  localparam integer MODE1_LOAD_I = MODE1_RECOVER_CYC;
  // counter loads at counter width; counts above 4095 do not fit
  localparam [11:0] CONFIRM_LAST = CONFIRM_LAST_I[11:0];
  localparam [11:0] STBY_LOAD = STBY_LOAD_I[11:0];
  localparam [11:0] MODE1_LOAD = MODE1_LOAD_I[11:0];

  // reset release through two flops
  reg rst_meta_r;
  reg rst_n_r;

  always @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // sequencer state and next value
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  // wake was started by the auxiliary pin
  reg aux_wake_r;
  reg aux_wake_nxt;
  // previous level of the auxiliary pin for edge detection
  reg aux_d_r;
  // confirmation window counter
  reg [11:0] conf_cnt_r;
  reg [11:0] conf_cnt_nxt;
  // chip status control register
  reg [7:0] csc_r;
  // mode decoded last cycle, for recovery timing
  reg [2:0] mode_prev_r;
  // rf recovery counter
  reg [11:0] rec_cnt_r;
  // auxiliary clock divider tick
  wire aux_tick;

  // auxiliary pin rising edge
  wire aux_rise = I_AUX_WAKE_ENABLE_PIN & ~aux_d_r;
  // supplies settled and oscillator stable
  wire osc_ready = I_REG_SETTLED & I_OSC_STABLE;

  // decode an active mode code from the status register
  function [2:0] csc_mode;
    input [7:0] csc;
    begin
      if (csc[`RPMS_CSC_STANDBY_BIT])
        csc_mode = `RPMS_PM_STANDBY;
      else if (csc[`RPMS_CSC_RF_ON_BIT] && csc[`RPMS_CSC_HALF_PWR_BIT])
        csc_mode = `RPMS_PM_MODE3;
      else if (csc[`RPMS_CSC_RF_ON_BIT])
        csc_mode = `RPMS_PM_MODE4;
      else if (csc[`RPMS_CSC_RX_ONLY_BIT])
        csc_mode = `RPMS_PM_MODE2;
      else
        csc_mode = `RPMS_PM_MODE1;
    end
  endfunction

  // mode currently selected by the register
  wire [2:0] act_mode = csc_mode(csc_r);
  // rf section wanted: mode 2, 3 or 4
  wire rf_mode = (act_mode == `RPMS_PM_MODE2) | (act_mode == `RPMS_PM_MODE3) |
    (act_mode == `RPMS_PM_MODE4);
  // a recovery toward full operation starts this cycle
  wire rec_start = (state_r == ST_ACTIVE) && rf_mode && (mode_prev_r != act_mode) &&
    ((mode_prev_r == `RPMS_PM_STANDBY) || (mode_prev_r == `RPMS_PM_MODE1));

  // state transitions
  always @* begin
    state_nxt = state_r;
    aux_wake_nxt = aux_wake_r;
    conf_cnt_nxt = conf_cnt_r;
    case (state_r)
      ST_DOWN, ST_SLEEP: begin
        if (I_MAIN_ENABLE) begin
          state_nxt = ST_START;
          aux_wake_nxt = 1'b0;
        end else if (aux_rise) begin
          state_nxt = ST_START;
          aux_wake_nxt = 1'b1;
        end else if (I_AUX_WAKE_ENABLE_PIN) begin
          state_nxt = ST_SLEEP;
        end else begin
          state_nxt = ST_DOWN;
        end
      end
      ST_START: begin
        if (osc_ready && I_MAIN_ENABLE) begin
          state_nxt = ST_ACTIVE;
          // main confirmed early: nothing left to time out
          aux_wake_nxt = 1'b0;
        end else if (osc_ready && aux_wake_r) begin
          // aux wake: host must confirm within the window
          state_nxt = ST_CONFIRM;
          conf_cnt_nxt = 12'h000;
        end else if (!I_MAIN_ENABLE && !aux_wake_r) begin
          // main enable dropped before the clock switch
          state_nxt = I_AUX_WAKE_ENABLE_PIN ? ST_SLEEP : ST_DOWN;
        end
      end
      ST_CONFIRM: begin
        if (I_MAIN_ENABLE) begin
          state_nxt = ST_ACTIVE;
          aux_wake_nxt = 1'b0;
        end else if (conf_cnt_r == CONFIRM_LAST) begin
          state_nxt = ST_DOWN;
          aux_wake_nxt = 1'b0;
        end else begin
          conf_cnt_nxt = conf_cnt_r + 12'h001;
        end
      end
      ST_ACTIVE: begin
        // main enable low leaves active operation
        if (!I_MAIN_ENABLE)
          state_nxt = I_AUX_WAKE_ENABLE_PIN ? ST_SLEEP : ST_DOWN;
      end
      default: begin
        state_nxt = ST_DOWN;
        aux_wake_nxt = 1'b0;
        conf_cnt_nxt = 12'h000;
      end
    endcase
  end

  // state registers
  always @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_DOWN;
      aux_wake_r <= 1'b0;
      conf_cnt_r <= 12'h000;
      // high, so a pin already high at reset release is no wake edge
      aux_d_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      aux_wake_r <= aux_wake_nxt;
      conf_cnt_r <= conf_cnt_nxt;
      aux_d_r <= I_AUX_WAKE_ENABLE_PIN;
    end
  end

  // status control register, lost whenever the reader powers off
  always @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      csc_r <= `RPMS_CSC_RESET;
    end else if (state_r == ST_DOWN || state_r == ST_SLEEP) begin
      csc_r <= `RPMS_CSC_RESET;
    end else if (I_CSC_WR && state_r == ST_ACTIVE) begin
      csc_r <= I_CSC_WDATA;
    end
  end

  // recovery timing toward an rf mode
  always @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_prev_r <= `RPMS_PM_MODE1;
      rec_cnt_r <= 12'h000;
    end else begin
      mode_prev_r <= (state_r == ST_ACTIVE) ? act_mode : `RPMS_PM_MODE1;
      if (state_r != ST_ACTIVE) begin
        rec_cnt_r <= 12'h000;
      end else if (rec_start && mode_prev_r == `RPMS_PM_STANDBY) begin
        rec_cnt_r <= STBY_LOAD;
      end else if (rec_start) begin
        rec_cnt_r <= MODE1_LOAD;
      // count down, holding at zero
      end else if (rec_cnt_r != 12'h000) begin
        rec_cnt_r <= rec_cnt_r - 12'h001;
      end
    end
  end

  // auxiliary clock runs in sleep and until the clock switch
  wire aux_run = (state_r == ST_SLEEP) || (state_r == ST_START);

  rpms_aux_div #(
    .HALF_CYC(`RPMS_AUX_HALF_CYC)
  ) u_aux_div (
    .i_clk(I_CLK),
    .i_rst_n(rst_n_r),
    .i_run(aux_run),
    .o_tick(aux_tick)
  );

  // registered outputs driven from the state
  always @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      O_CSC_RDATA <= 8'h00;
      O_REG_ENABLE <= 1'b0;
      O_OSC_ENABLE <= 1'b0;
      O_HOST_SUPPLY_EN <= 1'b0;
      O_HOST_CLOCK_OUTPUT <= 1'b0;
      O_HOST_CLOCK_SEL_HF <= 1'b0;
      O_TX_ENABLE <= 1'b0;
      O_RX_ENABLE <= 1'b0;
      O_HALF_POWER <= 1'b0;
      O_SUPPLY_5V <= 1'b1;
      O_RF_READY <= 1'b0;
      O_POWER_MODE <= `RPMS_PM_DOWN;
    end else begin
      // readback one cycle behind the register
      O_CSC_RDATA <= csc_r;
      O_SUPPLY_5V <= csc_r[`RPMS_CSC_SUPPLY_5V_BIT];
      O_REG_ENABLE <= (state_r == ST_START) || (state_r == ST_CONFIRM) ||
        (state_r == ST_ACTIVE);
      O_OSC_ENABLE <= (state_r == ST_START) || (state_r == ST_CONFIRM) ||
        (state_r == ST_ACTIVE);
      O_HOST_SUPPLY_EN <= (state_r != ST_DOWN);
      O_HOST_CLOCK_SEL_HF <= (state_r == ST_CONFIRM) || (state_r == ST_ACTIVE);
      if (!aux_run)
        O_HOST_CLOCK_OUTPUT <= 1'b0;
      else if (aux_tick)
        O_HOST_CLOCK_OUTPUT <= ~O_HOST_CLOCK_OUTPUT;
      if (state_r == ST_ACTIVE) begin
        O_TX_ENABLE <= (act_mode == `RPMS_PM_MODE3) || (act_mode == `RPMS_PM_MODE4);
        O_RX_ENABLE <= rf_mode;
        O_HALF_POWER <= (act_mode == `RPMS_PM_MODE3);
        // ready once the recovery count has run out
        O_RF_READY <= rf_mode && !rec_start && (rec_cnt_r <= 12'h001);
        O_POWER_MODE <= act_mode;
      end else begin
        O_TX_ENABLE <= 1'b0;
        O_RX_ENABLE <= 1'b0;
        O_HALF_POWER <= 1'b0;
        O_RF_READY <= 1'b0;
        if (state_r == ST_SLEEP)
          O_POWER_MODE <= `RPMS_PM_SLEEP;
        else if (state_r == ST_DOWN)
          O_POWER_MODE <= `RPMS_PM_DOWN;
        else
          O_POWER_MODE <= `RPMS_PM_START;
      end
    end
  end

endmodule // rpms_sequencer
`default_nettype wire

// file: testbench/rpms_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// regulators and oscillator seen from the sequencer
module rpms_analog_model #(
  parameter SETTLE_CYC = 12
) (
  input wire logic i_clk,
  input wire logic i_reg_enable,
  input wire logic i_osc_enable,
  output wire logic o_reg_settled,
  output wire logic o_osc_stable
);
  int reg_cnt = 0; // cycles since regulators on
  int osc_cnt = 0; // cycles since oscillator on
  // time since power-up, cleared when switched off
  always @(posedge i_clk) begin
    reg_cnt <= i_reg_enable ? reg_cnt + 1 : 0;
    osc_cnt <= i_osc_enable ? osc_cnt + 1 : 0;
  end
  // oscillator settles later than the supplies
  assign o_reg_settled = reg_cnt >= SETTLE_CYC;
  assign o_osc_stable = osc_cnt >= SETTLE_CYC + 4;
endmodule // rpms_analog_model
`default_nettype wire

// file: testbench/rpms_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// pin-level checks of the power sequencer
module rpms_monitor #(
  parameter CONFIRM_CYC = 2000,
  parameter STBY_RECOVER_CYC = 2000,
  parameter MODE1_RECOVER_CYC = 500
) (
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_MAIN_ENABLE,
  input wire logic I_AUX_WAKE_ENABLE_PIN,
  input wire logic I_REG_SETTLED,
  input wire logic I_OSC_STABLE,
  input wire logic I_CSC_WR,
  input wire logic [7:0] I_CSC_WDATA,
  input wire logic O_REG_ENABLE,
  input wire logic O_OSC_ENABLE,
  input wire logic O_HOST_SUPPLY_EN,
  input wire logic O_HOST_CLOCK_OUTPUT,
  input wire logic O_HOST_CLOCK_SEL_HF,
  input wire logic O_TX_ENABLE,
  input wire logic O_RX_ENABLE,
  input wire logic O_HALF_POWER,
  input wire logic O_RF_READY,
  input wire logic [2:0] O_POWER_MODE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  int cnf_r; // cycles waiting for confirmation
  int rec_r; // cycles of rf recovery
  logic from_m1_r; // rf recovery started from mode 1
  // mode expected from a register value
  function automatic [2:0] pick(input [7:0] d);
    pick = d[7] ? 3'h3 : d[5] ? (d[4] ? 3'h6 : 3'h7) : d[1] ? 3'h5 : 3'h4;
  endfunction
  // wait counters
  always @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnf_r <= 0;
      rec_r <= 0;
      from_m1_r <= 1'b0;
    end else begin
      cnf_r <= (O_POWER_MODE == 3'h2 && O_HOST_CLOCK_SEL_HF) ? cnf_r + 1 : 0;
      rec_r <= (O_POWER_MODE >= 3'h5 && !O_RF_READY) ? rec_r + 1 : 0;
      // mode 1 arms the short bound, standby disarms it; the long bound always applies
      if (O_POWER_MODE == 3'h4)
        from_m1_r <= 1'b1;
      else if (O_POWER_MODE == 3'h3)
        from_m1_r <= 1'b0;
    end
  end
  down_off_a: assert property (O_POWER_MODE == 3'h0 |-> !(O_TX_ENABLE | O_RX_ENABLE
    | O_HOST_SUPPLY_EN | O_HOST_CLOCK_OUTPUT | O_HOST_CLOCK_SEL_HF | O_REG_ENABLE))
    else $error("power down leaves an output on");
  sleep_keep_a: assert property (O_POWER_MODE == 3'h1 |-> O_HOST_SUPPLY_EN
    && !(O_TX_ENABLE | O_RX_ENABLE | O_HOST_CLOCK_SEL_HF)) else $error("bad sleep outputs");
  main_wake_a: assert property (O_POWER_MODE == 3'h0 && I_MAIN_ENABLE
    |-> ##[1:3] O_REG_ENABLE && O_OSC_ENABLE) else $error("main enable did not start");
  aux_wake_a: assert property ($rose(I_AUX_WAKE_ENABLE_PIN) && O_POWER_MODE == 3'h0
    |-> ##[1:4] O_REG_ENABLE && O_OSC_ENABLE) else $error("aux edge did not start");
  hf_switch_a: assert property (O_POWER_MODE == 3'h2 && I_REG_SETTLED && I_OSC_STABLE
    && !O_HOST_CLOCK_SEL_HF |-> ##[1:4] O_HOST_CLOCK_SEL_HF)
    else $error("host clock not switched");
  confirm_bound_a: assert property (cnf_r <= CONFIRM_CYC + 2)
    else $error("confirmation window overrun");
  stay_active_a: assert property (I_MAIN_ENABLE && $past(I_MAIN_ENABLE)
    && O_POWER_MODE >= 3'h3 |-> ##2 O_POWER_MODE >= 3'h3) else $error("left active");
  mode_pick_a: assert property (I_CSC_WR && O_POWER_MODE >= 3'h3
    |-> ##2 O_POWER_MODE == pick($past(I_CSC_WDATA, 2))) else $error("wrong mode");
  rf_path_a: assert property ($stable(O_POWER_MODE) && O_POWER_MODE >= 3'h3
    |-> O_TX_ENABLE == (O_POWER_MODE[2] & O_POWER_MODE[1])
    && O_RX_ENABLE == (O_POWER_MODE[2] & |O_POWER_MODE[1:0])) else $error("rf path");
  half_power_a: assert property ($stable(O_POWER_MODE) && O_POWER_MODE >= 3'h6
    |-> O_HALF_POWER == !O_POWER_MODE[0]) else $error("power level wrong");
  recover_bound_a: assert property (rec_r <= STBY_RECOVER_CYC + 2)
    else $error("rf recovery too slow");
  mode1_recover_a: assert property (from_m1_r |-> rec_r <= MODE1_RECOVER_CYC + 2)
    else $error("mode 1 recovery too slow");
endmodule // rpms_monitor
bind rpms_sequencer rpms_monitor #(.CONFIRM_CYC(CONFIRM_CYC),
  .STBY_RECOVER_CYC(STBY_RECOVER_CYC), .MODE1_RECOVER_CYC(MODE1_RECOVER_CYC))
  mon (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
  .I_MAIN_ENABLE(I_MAIN_ENABLE), .I_AUX_WAKE_ENABLE_PIN(I_AUX_WAKE_ENABLE_PIN),
  .I_REG_SETTLED(I_REG_SETTLED), .I_OSC_STABLE(I_OSC_STABLE), .I_CSC_WR(I_CSC_WR),
  .I_CSC_WDATA(I_CSC_WDATA), .O_REG_ENABLE(O_REG_ENABLE), .O_OSC_ENABLE(O_OSC_ENABLE),
  .O_HOST_SUPPLY_EN(O_HOST_SUPPLY_EN), .O_HOST_CLOCK_OUTPUT(O_HOST_CLOCK_OUTPUT),
  .O_HOST_CLOCK_SEL_HF(O_HOST_CLOCK_SEL_HF), .O_TX_ENABLE(O_TX_ENABLE),
  .O_RX_ENABLE(O_RX_ENABLE), .O_HALF_POWER(O_HALF_POWER), .O_RF_READY(O_RF_READY),
  .O_POWER_MODE(O_POWER_MODE));
`default_nettype wire

// file: testbench/reader_power_mode_sequencer_bench.sv
`timescale 1ns/1ns
`default_nettype none
// pin-driven tests of the power sequencer
module reader_power_mode_sequencer_bench;
  localparam CNF = 40; // shortened confirmation window
  localparam STB = 20; // shortened standby recovery
  localparam M1 = 10; // shortened mode 1 recovery
  localparam GAP = 200; // enable spacing, shortened for run time
  logic clk, rstn, main, aux, wr, settled, stable;
  logic [7:0] wd, rd;
  logic reg_en, osc_en, sup_en, hclk, sel_hf, tx, rx, half, v5, rdy;
  logic [2:0] pm;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // register value, settle wait, expected {half,5v,tx,rx,ready,mode}
  logic [7:0] td[9] = '{8'h81, 8'h21, 8'h01, 8'h31, 8'h03, 8'h20, 8'h02, 8'h00, 8'h80};
  int tw[9] = '{10, STB + 4, 10, M1 + 4, 24, 24, 24, 10, 10};
  logic [7:0] te[9] = '{8'h43, 8'h7f, 8'h44, 8'hfe, 8'h5d, 8'h3f, 8'h1d, 8'h04, 8'h03};
  rpms_sequencer #(.CONFIRM_CYC(CNF), .STBY_RECOVER_CYC(STB), .MODE1_RECOVER_CYC(M1)) DUT (
    .I_CLK(clk), .I_RSTN(rstn), .I_MAIN_ENABLE(main), .I_AUX_WAKE_ENABLE_PIN(aux),
    .I_REG_SETTLED(settled), .I_OSC_STABLE(stable), .I_CSC_WR(wr), .I_CSC_WDATA(wd),
    .O_CSC_RDATA(rd), .O_REG_ENABLE(reg_en), .O_OSC_ENABLE(osc_en),
    .O_HOST_SUPPLY_EN(sup_en), .O_HOST_CLOCK_OUTPUT(hclk), .O_HOST_CLOCK_SEL_HF(sel_hf),
    .O_TX_ENABLE(tx), .O_RX_ENABLE(rx), .O_HALF_POWER(half), .O_SUPPLY_5V(v5),
    .O_RF_READY(rdy), .O_POWER_MODE(pm));
  rpms_analog_model ana (.i_clk(clk), .i_reg_enable(reg_en), .i_osc_enable(osc_en),
    .o_reg_settled(settled), .o_osc_stable(stable));
  // 50 ns period
  always #25 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle register write strobe
  task automatic csc_write(input logic [7:0] d);
    wd = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  // bounded wait for the clock switch
  task automatic wait_hf;
    int k;
    k = 0;
    while (sel_hf !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    check({7'h0, sel_hf}, 8'h01);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // main sequence
  initial begin
    logic v;
    int k;
    clk = 0; rstn = 0; main = 0; aux = 0; wr = 0; wd = 8'h00;
    tick(6);
    rstn = 1;
    tick(4);
    check(rd, 8'h01);
    check({sup_en, reg_en, hclk, v5, 1'b0, pm}, 8'h10);
    csc_write(8'h21);
    tick(3);
    check(rd, 8'h01);
    main = 1;
    wait_hf;
    tick(3);
    check({5'h0, pm}, 8'h04);
    for (int i = 0; i < 9; i++) begin
      csc_write(td[i]);
      tick(tw[i]);
      check({half, v5, tx, rx, rdy, pm}, te[i]);
      check(rd, td[i]);
      check({7'h0, sel_hf}, 8'h01);
    end
    main = 0;
    tick(4);
    check({tx, rx, sup_en, sel_hf, hclk, pm}, 8'h00);
    check(rd, 8'h01);
    // host spacing between enable changes
    tick(GAP);
    aux = 1;
    wait_hf;
    check({5'h0, pm}, 8'h02);
    tick(5);
    aux = 0;
    tick(CNF + 10);
    check({5'h0, pm}, 8'h00);
    tick(GAP);
    aux = 1;
    wait_hf;
    // main confirms later, while aux stays high
    tick(10);
    main = 1;
    tick(CNF + 20);
    check({5'h0, pm}, 8'h04);
    main = 0;
    tick(5);
    check({sup_en, tx, rx, sel_hf, 1'b0, pm}, 8'h81);
    v = hclk;
    k = 0;
    while (hclk === v && k < 400) begin
      tick(1);
      k++;
    end
    check({7'h0, hclk}, {7'h0, ~v});
    // one half period: 20 MHz over twice 60 kHz, rounded down to 166
    v = hclk;
    k = 0;
    while (hclk === v && k < 400) begin
      tick(1);
      k++;
    end
    check(k[7:0], 8'ha6);
    aux = 0;
    tick(5);
    check({5'h0, pm}, 8'h00);
    print_verdict;
  end
endmodule // reader_power_mode_sequencer_bench
`default_nettype wire
